// ---- bench/adcsc_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_conv_model #(
  parameter int LAT = 5
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        diff_i,
  input  wire logic        temp_i,
  input  wire logic [2:0]  chan_i,
  output logic             done_o,
  output logic      [11:0] data_o
);
  int          cnt;
  logic [7:0]  temps;
  logic [11:0] word;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      temps <= 8'h00;
      done_o <= 1'b0;
      data_o <= 12'h000;
    end else begin
      done_o <= (cnt == 1);
      data_o <= (cnt == 1) ? word : ~data_o;
      if (cnt > 0) cnt <= cnt - 1;
      if (req_i) begin
        cnt <= LAT;
        word <= temp_i ? {4'hf, temps} : {8'ha0, diff_i, chan_i};
        if (temp_i) temps <= temps + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/adcsc_scan_ctrl_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_scan_ctrl_bench;
  import adcsc_pkg::*;
  logic        clock_i = 0, rst_i = 1, cs_n = 1, sclk = 0, din = 0, start_n = 1, demand = 0;
  logic        dout, req, diff, temp, done, busy, ref_on, ext, cnvact, negact;
  logic        adcint, dacint, adcdiff, pace;
  logic [2:0]  chan;
  logic [11:0] data;
  logic [9:0]  dac_q;
  logic [15:0] rx;
  logic [15:0] expq[$];
  int          mismatches = 0, cmp_count = 0;
  int          temp_lat = 0, busy_cyc = 0, paces = 0, p0 = 0;
  always #20 clock_i = ~clock_i;
  // cycles from scan start to the temperature request, and pace pulses seen
  always @(posedge clock_i) begin
    busy_cyc <= busy ? busy_cyc + 1 : 0;
    if (req && temp) temp_lat <= busy_cyc;
    if (pace) paces <= paces + 1;
  end
  adcsc_scan_ctrl DUT (.clock_i(clock_i), .rst_i(rst_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_din_i(din), .spi_dout_o(dout), .conversion_start_pin_n_i(start_n),
    .dac_ref_demand_i(demand), .dac_code_i(10'h155), .dac_code_o(dac_q), .adc_conv_req_o(req),
    .adc_conv_chan_o(chan), .adc_conv_diff_o(diff), .adc_conv_temp_o(temp), .adc_pace_o(pace),
    .adc_ext_clock_o(ext), .adc_done_i(done), .adc_data_i(data), .ref_on_o(ref_on),
    .adc_ref_internal_o(adcint), .dac_ref_internal_o(dacint),
    .adc_ref_differential_o(adcdiff), .negative_reference_pin_active_o(negact),
    .conversion_start_pin_active_o(cnvact), .busy_o(busy));
  adcsc_conv_model u_conv (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .diff_i(diff),
    .temp_i(temp), .chan_i(chan), .done_o(done), .data_o(data));
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // serial clock 320 ns, half high half low
  task automatic spi(input logic [15:0] tx, input int nb);
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < nb; i++) begin
      din <= tx[15-i];
      sclk <= 1'b1;
      tick(4);
      rx[15-i] = dout;
      sclk <= 1'b0;
      tick(4);
    end
    cs_n <= 1'b1;
    tick(6);
  endtask
  task automatic idle();
    int w;
    w = 0;
    while (busy !== 1'b0 && w < 4000) begin
      tick(1);
      w++;
    end
    chk({15'h0, busy}, 16'h0000);
  endtask
  task automatic kick();
    start_n <= 1'b0;
    tick(4);
    start_n <= 1'b1;
    tick(6);
  endtask
  // issue a conversion byte, optional start pulse, then read back the queue
  task automatic scan(input logic [7:0] cmd, input logic pulse);
    if (cmd != 8'h00) spi({cmd, 8'h00}, 8);
    if (pulse) kick();
    idle();
    while (expq.size() > 0) begin
      spi(16'h0000, 16);
      chk(rx, expq.pop_front());
    end
    spi(16'h0000, 16);
    chk(rx, 16'h0000);
    $display("test done, command %h", cmd);
  endtask
  function automatic logic [15:0] w(input logic d, input logic [2:0] c);
    return {4'h0, 8'ha0, d, c};
  endfunction
  function automatic logic [15:0] tw(input logic [7:0] n);
    return {8'h0f, n};
  endfunction
  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(4);
    chk({11'h0, ext, cnvact, negact, adcint, dacint}, 16'h0002);
    chk({6'h0, dac_q}, 16'h0155);
    p0 = paces;
    tick(64);
    chk(16'(paces - p0), 16'(64 / PACE_DIV_DEF));
    expq = '{tw(0), w(0, 0), w(0, 1), w(0, 2)};
    scan(8'hd1, 1'b0);
    chk(16'(temp_lat), 16'(TEMP_WAKE_DLY_CYC));
    expq = '{w(0, 5), w(0, 6), w(0, 7)};
    scan(8'haa, 1'b0);
    spi(16'h2100, 8);
    for (int i = 0; i < 8; i++) expq.push_back(w(0, 3));
    scan(8'h9c, 1'b0);
    expq = '{w(0, 4)};
    scan(8'ha6, 1'b0);
    spi(16'h4800, 8);
    spi(16'h8700, 8);
    kick();
    idle();
    expq = '{tw(2), w(0, 0), w(0, 0)};
    scan(8'h00, 1'b1);
    spi(16'h6910, 16);
    expq = '{w(1, 0), w(0, 2), w(0, 3)};
    scan(8'h98, 1'b0);
    spi(16'h4800, 8);
    chk({15'h0, cnvact}, 16'h0001);
    expq = '{w(0, 6)};
    scan(8'hb2, 1'b1);
    spi(16'h7c00, 8);
    chk({11'h0, ext, cnvact, negact, adcint, adcdiff}, 16'h0015);
    expq = '{w(0, 5), w(0, 7)};
    scan(8'haa, 1'b0);
    p0 = paces;
    spi(16'h0900, 8);
    chk(16'(paces - p0), 16'h0008);
    chk({15'h0, ref_on}, 16'h0001);
    spi(16'h6008, 16);
    demand <= 1'b1;
    tick(2);
    chk({14'h0, ref_on, dacint}, 16'h0003);
    expq = '{tw(3), w(1, 0)};
    scan(8'h87, 1'b0);
    chk(16'(temp_lat), 16'(TEMP_HOLD_DLY_CYC));
    finish_test();
  end
  initial begin
    tick(40000);
    mismatches++;
    finish_test();
  end
endmodule
bind adcsc_scan_ctrl adcsc_scan_ctrl_props u_props (.clock_i(clock_i), .rst_i(rst_i),
  .dac_ref_demand_i(dac_ref_demand_i), .adc_conv_req_o(adc_conv_req_o),
  .adc_conv_chan_o(adc_conv_chan_o), .adc_conv_diff_o(adc_conv_diff_o),
  .adc_conv_temp_o(adc_conv_temp_o), .adc_ext_clock_o(adc_ext_clock_o), .ref_on_o(ref_on_o),
  .adc_ref_internal_o(adc_ref_internal_o), .dac_ref_internal_o(dac_ref_internal_o),
  .adc_ref_differential_o(adc_ref_differential_o),
  .negative_reference_pin_active_o(negative_reference_pin_active_o),
  .conversion_start_pin_active_o(conversion_start_pin_active_o), .busy_o(busy_o));
`default_nettype wire

// ---- bench/adcsc_scan_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_scan_ctrl_props (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       dac_ref_demand_i,
  input wire logic       adc_conv_req_o,
  input wire logic [2:0] adc_conv_chan_o,
  input wire logic       adc_conv_diff_o,
  input wire logic       adc_conv_temp_o,
  input wire logic       adc_ext_clock_o,
  input wire logic       ref_on_o,
  input wire logic       adc_ref_internal_o,
  input wire logic       dac_ref_internal_o,
  input wire logic       adc_ref_differential_o,
  input wire logic       negative_reference_pin_active_o,
  input wire logic       conversion_start_pin_active_o,
  input wire logic       busy_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_start_pin; conversion_start_pin_active_o |-> !adc_ext_clock_o; endproperty
  a_start_pin: assert property (p_start_pin) else $error("start pin in serial clock mode");
  property p_neg_ref; adc_ref_internal_o ^ negative_reference_pin_active_o; endproperty
  a_neg_ref: assert property (p_neg_ref) else $error("shared pin role wrong");
  property p_diff_ref; adc_ref_differential_o |-> negative_reference_pin_active_o; endproperty
  a_diff_ref: assert property (p_diff_ref) else $error("differential ref decode");
  property p_dac_ref; dac_ref_internal_o |-> adc_ref_internal_o; endproperty
  a_dac_ref: assert property (p_dac_ref) else $error("dac ref decode");
  property p_ref_on; dac_ref_demand_i && dac_ref_internal_o |-> ref_on_o; endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not held on");
  property p_pair; adc_conv_req_o && adc_conv_diff_o |-> !adc_conv_chan_o[0]; endproperty
  a_pair: assert property (p_pair) else $error("pair request on odd channel");
  property p_skip_cnv;
    adc_conv_req_o && conversion_start_pin_active_o && !adc_conv_temp_o |-> adc_conv_chan_o != 3'h7;
  endproperty
  a_skip_cnv: assert property (p_skip_cnv) else $error("start pin channel converted");
  property p_skip_ref;
    adc_conv_req_o && negative_reference_pin_active_o && !adc_conv_temp_o |-> adc_conv_chan_o != 3'h6;
  endproperty
  a_skip_ref: assert property (p_skip_ref) else $error("reference pin channel converted");
  property p_req_busy; adc_conv_req_o |-> busy_o ##1 !adc_conv_req_o; endproperty
  a_req_busy: assert property (p_req_busy) else $error("request outside scan");
endmodule
`default_nettype wire

// ---- design/adcsc_pkg.sv ----
package adcsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command byte decode
  localparam int CONV_SEL_BIT   = 7;
  localparam int SETUP_SEL_BIT  = 6;
  localparam int CHAN_HI_BIT    = 5;
  localparam int CHAN_LO_BIT    = 3;
  localparam int SCAN_HI_BIT    = 2;
  localparam int SCAN_LO_BIT    = 1;
  localparam int TEMP_BIT       = 0;
  localparam int CLK_HI_BIT     = 5;
  localparam int CLK_LO_BIT     = 4;
  localparam int REF_HI_BIT     = 3;
  localparam int REF_LO_BIT     = 2;
  localparam int DIFF_HI_BIT    = 1;
  localparam int DIFF_LO_BIT    = 0;
  localparam logic [2:0] AVG_PREFIX   = 3'h1;
  localparam logic [4:0] FORCE_PREFIX = 5'h01;
  localparam int REPEAT_HI_BIT  = 1;
  localparam int REPEAT_LO_BIT  = 0;
  localparam int FORCE_BIT      = 0;

  localparam logic [1:0] SCAN_LOW_UP   = 2'h0;
  localparam logic [1:0] SCAN_N_UP     = 2'h1;
  localparam logic [1:0] SCAN_REPEAT   = 2'h2;
  localparam logic [1:0] SCAN_ONCE     = 2'h3;
  localparam logic [1:0] REF_INT_BOTH  = 2'h0;
  localparam logic [1:0] REF_EXT_DIFF  = 2'h3;
  localparam logic [1:0] CLK_EXT_SCLK  = 2'h3;
  localparam logic [1:0] DIFF_UNIPOLAR = 2'h1;
  localparam logic [1:0] DIFF_BIPOLAR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [1:0] CLOCK_MODE_RST = 2'h2;
  localparam logic [1:0] REF_MODE_RST   = 2'h2;
  localparam logic [1:0] DIFF_ADDR_RST  = 2'h0;
  localparam logic [1:0] REPEAT_RST     = 2'h0;
  localparam logic [3:0] PAIR_MASK_RST  = 4'h0;
  localparam logic [7:0] CONV_CMD_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing and sizes
  localparam int CLK_HZ            = 25_000_000;
  localparam int TEMP_HOLD_DLY_CYC = 188;
  localparam int TEMP_WAKE_DLY_CYC = 244;
  localparam int PACE_DIV_DEF      = 8;
  localparam int FIFO_DEPTH        = 16;
  localparam int RESULT_W          = 12;
  localparam int LEAD_ZEROS        = 4;
  localparam int WORD_W            = RESULT_W + LEAD_ZEROS;
  localparam int DAC_W             = 10;
  localparam int DAC_FULL_SCALE    = 1024;
  localparam int NUM_CH_DEF        = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_TEMP_WAIT,
    ST_NEXT,
    ST_CONV_WAIT
  } adcsc_state_e;

  // results per repeat scan: 4, 8, 12 or 16
  function automatic logic [4:0] repeat_results(input logic [1:0] rc);
    repeat_results = {1'b0, rc, 2'b00} + 5'h04;
  endfunction

  // put a result into its two-byte readout form
  function automatic logic [WORD_W-1:0] out_word(input logic [RESULT_W-1:0] r);
    out_word = {{LEAD_ZEROS{1'b0}}, r};
  endfunction

endpackage

// ---- design/adcsc_result_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_result_fifo
  import adcsc_pkg::*;
#(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic                  pop_valid_o,
  output logic      [WIDTH-1:0] pop_data_o,
  output logic                  full_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("result fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } adcsc_fifo_s;

  adcsc_fifo_s s;
  adcsc_fifo_s next_s;
  logic        do_pop;

  assign full_o      = (s.cnt == (AW + 1)'(DEPTH));
  assign pop_valid_o = (s.cnt != '0);
  assign pop_data_o  = s.mem[s.rd];
  assign do_pop      = pop_i & pop_valid_o;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    if (push_i) begin
      next_s.mem[s.wr] = push_data_i;
      next_s.wr        = s.wr + 1'b1;
    end
    if (do_pop || (push_i && full_o)) begin
      next_s.rd = s.rd + 1'b1;
    end
    if (push_i && !do_pop && !full_o) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (do_pop && !push_i) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// ---- design/adcsc_scan_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module adcsc_scan_ctrl
  import adcsc_pkg::*;
#(
  parameter int NUM_CH      = NUM_CH_DEF,
  parameter int CNV_PIN_CH  = 7,
  parameter int NEGATIVE_REFERENCE_PIN_PIN_CH = 6,
  parameter int PACE_DIV    = PACE_DIV_DEF
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                spi_cs_n_i,
  input  wire logic                spi_sclk_i,
  input  wire logic                spi_din_i,
  output logic                     spi_dout_o,
  input  wire logic                conversion_start_pin_n_i,
  input  wire logic                dac_ref_demand_i,
  input  wire logic [DAC_W-1:0]    dac_code_i,
  output logic      [DAC_W-1:0]    dac_code_o,
  output logic                     adc_conv_req_o,
  output logic      [2:0]          adc_conv_chan_o,
  output logic                     adc_conv_diff_o,
  output logic                     adc_conv_temp_o,
  output logic                     adc_pace_o,
  output logic                     adc_ext_clock_o,
  input  wire logic                adc_done_i,
  input  wire logic [RESULT_W-1:0] adc_data_i,
  output logic                     ref_on_o,
  output logic                     adc_ref_internal_o,
  output logic                     dac_ref_internal_o,
  output logic                     adc_ref_differential_o,
  output logic                     negative_reference_pin_active_o,
  output logic                     conversion_start_pin_active_o,
  output logic                     busy_o
);

  if (NUM_CH != 4 && NUM_CH != 8) begin : g_bad_ch
    $error("channel count must be 4 or 8");
  end
  if (PACE_DIV < 2 || PACE_DIV > 16) begin : g_bad_div
    $error("pace divider must be 2 to 16");
  end

  typedef struct packed {
    logic [2:0]          cs_sync;
    logic [2:0]          sclk_sync;
    logic [1:0]          din_sync;
    logic [2:0]          cnv_sync;
    logic [7:0]          rx;
    logic [2:0]          rx_cnt;
    logic                mode_pending;
    logic                frame_ignore;
    logic [WORD_W-1:0]   tx;
    logic [1:0]          clock_mode;
    logic [1:0]          ref_mode;
    logic [1:0]          diff_addr;
    logic [3:0]          pair_uni;
    logic [3:0]          pair_bip;
    logic [1:0]          repeat_count;
    logic                force_on;
    logic [7:0]          conv_cmd;
    logic                conv_go;
    adcsc_state_e        state;
    logic [3:0]          cur;
    logic [4:0]          reps;
    logic [7:0]          delay;
    logic                req;
    logic [2:0]          req_chan;
    logic                req_diff;
    logic                req_temp;
    logic [RESULT_W-1:0] temp_data;
    logic                temp_valid;
    logic [3:0]          pace_cnt;
    logic                pace;
    logic [DAC_W-1:0]    dac_code;
  } adcsc_ctrl_s;

  adcsc_ctrl_s         s;
  adcsc_ctrl_s         next_s;
  logic                cs_low;
  logic                cs_fall;
  logic                sclk_fall;
  logic                sclk_rise;
  logic                cnv_fall;
  logic                byte_done;
  logic [7:0]          rx_byte;
  logic [2:0]          chan_n;
  logic [1:0]          scan_mode;
  logic [3:0]          pair_diff;
  logic                sel_diff;
  logic [2:0]          sel_ch;
  logic                sel_block;
  logic [3:0]          cur_next;
  logic                range_done;
  logic                ref_hold;
  logic                start;
  logic                fifo_push;
  logic                fifo_pop;
  logic                fifo_valid;
  logic [WORD_W-1:0]   fifo_data;

  // true when the channel, or either pin of its pair, serves another function
  function automatic logic chan_blocked(input logic [2:0] ch, input logic diff,
                                        input logic [1:0] ck, input logic [1:0] rf);
    logic hit_cnv;
    logic hit_negative_reference_pin;
    hit_cnv  = (ch == 3'(CNV_PIN_CH)) || (diff && (ch + 3'h1) == 3'(CNV_PIN_CH));
    hit_negative_reference_pin = (ch == 3'(NEGATIVE_REFERENCE_PIN_PIN_CH)) || (diff && (ch + 3'h1) == 3'(NEGATIVE_REFERENCE_PIN_PIN_CH));
    chan_blocked = (hit_cnv && !ck[1]) || (hit_negative_reference_pin && rf[0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the resynchronised serial and conversion start pins
  assign cs_low    = ~s.cs_sync[1];
  assign cs_fall   = s.cs_sync[2] & ~s.cs_sync[1];
  assign sclk_fall = s.sclk_sync[2] & ~s.sclk_sync[1];
  assign sclk_rise = ~s.sclk_sync[2] & s.sclk_sync[1];
  assign cnv_fall  = s.cnv_sync[2] & ~s.cnv_sync[1];
  assign rx_byte   = {s.rx[6:0], s.din_sync[1]};
  assign byte_done = cs_low & sclk_fall & (s.rx_cnt == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // scan channel selection
  assign chan_n     = s.conv_cmd[CHAN_HI_BIT:CHAN_LO_BIT];
  assign scan_mode  = s.conv_cmd[SCAN_HI_BIT:SCAN_LO_BIT];
  assign pair_diff  = s.pair_uni | s.pair_bip;
  assign sel_diff   = pair_diff[s.cur[2:1]];
  assign sel_ch     = sel_diff ? {s.cur[2:1], 1'b0} : s.cur[2:0];
  assign sel_block  = chan_blocked(sel_ch, sel_diff, s.clock_mode, s.ref_mode);
  assign cur_next   = {1'b0, sel_ch} + (sel_diff ? 4'h2 : 4'h1);

  always_comb begin
    case (scan_mode)
      SCAN_LOW_UP: range_done = (s.cur > {1'b0, chan_n});
      SCAN_N_UP:   range_done = (s.cur >= 4'(NUM_CH));
      default:     range_done = (s.reps == 5'h00);
    endcase
  end

  assign ref_hold = s.force_on | (dac_ref_demand_i & (s.ref_mode == REF_INT_BOTH));
  assign start    = (s.conv_go & s.clock_mode[1]) | (cnv_fall & ~s.clock_mode[1]);

  assign fifo_push = (s.state == ST_CONV_WAIT) & adc_done_i;
  assign fifo_pop  = cs_fall & ~s.temp_valid;

  adcsc_result_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .push_i      (fifo_push),
    .push_data_i (out_word(adc_data_i)),
    .pop_i       (fifo_pop),
    .pop_valid_o (fifo_valid),
    .pop_data_o  (fifo_data),
    .full_o      ()
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s           = s;
    next_s.cs_sync   = {s.cs_sync[1:0], spi_cs_n_i};
    next_s.sclk_sync = {s.sclk_sync[1:0], spi_sclk_i};
    next_s.din_sync  = {s.din_sync[0], spi_din_i};
    next_s.cnv_sync  = {s.cnv_sync[1:0], conversion_start_pin_n_i};
    next_s.conv_go   = 1'b0;
    next_s.req       = 1'b0;
    next_s.dac_code  = dac_code_i;

    // serial command bytes, taken on falling serial clock
    if (!cs_low) begin
      next_s.rx_cnt       = 3'h0;
      next_s.mode_pending = 1'b0;
      next_s.frame_ignore = 1'b0;
    end else if (sclk_fall) begin
      next_s.rx     = rx_byte;
      next_s.rx_cnt = s.rx_cnt + 3'h1;
      next_s.tx     = {s.tx[WORD_W-2:0], 1'b0};
    end
    if (byte_done && !s.frame_ignore) begin
      if (s.mode_pending) begin
        next_s.mode_pending = 1'b0;
        if (s.diff_addr == DIFF_UNIPOLAR) begin
          next_s.pair_uni = rx_byte[7:4];
        end else begin
          next_s.pair_bip = rx_byte[7:4];
        end
      end else if (rx_byte[CONV_SEL_BIT]) begin
        next_s.conv_cmd = {2'b00, rx_byte[CHAN_HI_BIT:TEMP_BIT]};
        next_s.conv_go  = 1'b1;
      end else if (rx_byte[SETUP_SEL_BIT]) begin
        next_s.clock_mode   = rx_byte[CLK_HI_BIT:CLK_LO_BIT];
        next_s.ref_mode     = rx_byte[REF_HI_BIT:REF_LO_BIT];
        next_s.diff_addr    = rx_byte[DIFF_HI_BIT:DIFF_LO_BIT];
        next_s.mode_pending = (rx_byte[DIFF_HI_BIT:DIFF_LO_BIT] == DIFF_UNIPOLAR) ||
                              (rx_byte[DIFF_HI_BIT:DIFF_LO_BIT] == DIFF_BIPOLAR);
      end else if (rx_byte[7:5] == AVG_PREFIX) begin
        next_s.repeat_count = rx_byte[REPEAT_HI_BIT:REPEAT_LO_BIT];
      end else if (rx_byte[7:3] == FORCE_PREFIX) begin
        next_s.force_on = rx_byte[FORCE_BIT];
      end else begin
        next_s.frame_ignore = 1'b1;
      end
    end

    // readout word, loaded as the frame opens
    if (cs_fall) begin
      if (s.temp_valid) begin
        next_s.tx         = out_word(s.temp_data);
        next_s.temp_valid = 1'b0;
      end else if (fifo_valid) begin
        next_s.tx = fifo_data;
      end else begin
        next_s.tx = '0;
      end
    end

    // conversion pacing: divider or serial clock
    if (s.clock_mode == CLK_EXT_SCLK) begin
      next_s.pace     = sclk_rise;
      next_s.pace_cnt = 4'h0;
    end else if (s.pace_cnt == 4'(PACE_DIV - 1)) begin
      next_s.pace     = 1'b1;
      next_s.pace_cnt = 4'h0;
    end else begin
      next_s.pace     = 1'b0;
      next_s.pace_cnt = s.pace_cnt + 4'h1;
    end

    // scan sequencer
    case (s.state)
      ST_IDLE: begin
        if (start) begin
          next_s.cur  = (scan_mode == SCAN_LOW_UP) ? 4'h0 : {1'b0, chan_n};
          next_s.reps = (scan_mode == SCAN_REPEAT) ? repeat_results(s.repeat_count)
                                                   : 5'h01;
          if (s.conv_cmd[TEMP_BIT]) begin
            next_s.state = ST_SETTLE;
            next_s.delay = ref_hold ? 8'(TEMP_HOLD_DLY_CYC - 1)
                                    : 8'(TEMP_WAKE_DLY_CYC - 1);
          end else begin
            next_s.state = ST_NEXT;
          end
        end
      end
      ST_SETTLE: begin
        if (s.delay == 8'h00) begin
          next_s.req      = 1'b1;
          next_s.req_temp = 1'b1;
          next_s.req_diff = 1'b0;
          next_s.req_chan = 3'h0;
          next_s.state    = ST_TEMP_WAIT;
        end else begin
          next_s.delay = s.delay - 8'h01;
        end
      end
      ST_TEMP_WAIT: begin
        if (adc_done_i) begin
          next_s.temp_data  = adc_data_i;
          next_s.temp_valid = 1'b1;
          next_s.state      = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (range_done) begin
          next_s.state = ST_IDLE;
        end else if (sel_block) begin
          next_s.cur  = cur_next;
          next_s.reps = 5'h00;
          if (scan_mode == SCAN_LOW_UP || scan_mode == SCAN_N_UP) begin
            next_s.reps = s.reps;
          end
        end else begin
          next_s.req      = 1'b1;
          next_s.req_temp = 1'b0;
          next_s.req_diff = sel_diff;
          next_s.req_chan = sel_ch;
          next_s.state    = ST_CONV_WAIT;
        end
      end
      ST_CONV_WAIT: begin
        if (adc_done_i) begin
          next_s.state = ST_NEXT;
          if (scan_mode == SCAN_LOW_UP || scan_mode == SCAN_N_UP) begin
            next_s.cur = cur_next;
          end else begin
            next_s.reps = s.reps - 5'h01;
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
      end
    endcase

    // a fresh temperature result beats the read that clears the old one
    if (s.state == ST_TEMP_WAIT && adc_done_i) begin
      next_s.temp_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s              <= '0;
      s.cs_sync      <= 3'h7;
      s.sclk_sync    <= 3'h0;
      s.cnv_sync     <= 3'h7;
      s.clock_mode   <= CLOCK_MODE_RST;
      s.ref_mode     <= REF_MODE_RST;
      s.diff_addr    <= DIFF_ADDR_RST;
      s.pair_uni     <= PAIR_MASK_RST;
      s.pair_bip     <= PAIR_MASK_RST;
      s.repeat_count <= REPEAT_RST;
      s.conv_cmd     <= CONV_CMD_RST;
      s.state        <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign spi_dout_o                      = s.tx[WORD_W-1];
  assign dac_code_o                      = s.dac_code;
  assign adc_conv_req_o                  = s.req;
  assign adc_conv_chan_o                 = s.req_chan;
  assign adc_conv_diff_o                 = s.req_diff;
  assign adc_conv_temp_o                 = s.req_temp;
  assign adc_pace_o                      = s.pace;
  assign adc_ext_clock_o                 = (s.clock_mode == CLK_EXT_SCLK);
  assign ref_on_o                        = ref_hold | (s.state != ST_IDLE &&
                                           (s.conv_cmd[TEMP_BIT] || !s.ref_mode[0]));
  assign adc_ref_internal_o              = ~s.ref_mode[0];
  assign dac_ref_internal_o              = (s.ref_mode == REF_INT_BOTH);
  assign adc_ref_differential_o          = (s.ref_mode == REF_EXT_DIFF);
  assign negative_reference_pin_active_o = s.ref_mode[0];
  assign conversion_start_pin_active_o   = ~s.clock_mode[1];
  assign busy_o                          = (s.state != ST_IDLE);

endmodule
`default_nettype wire
